// file: design/tlqm_pkg.sv
// Shared constants and types of the line quality monitor
package tlqm_pkg;

  // Clock and time base
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned MS_PS         = 1000000000;
  localparam int unsigned MS_CYCLES     = MS_PS / CLK_PERIOD_PS;
  localparam int unsigned MS_PER_SEC    = 1000;
  localparam int unsigned SEC_PER_HOUR  = 3600;

  // Base interval choices in seconds
  localparam logic [6:0] BI_SHORT_S = 7'h3C;
  localparam logic [6:0] BI_LONG_S  = 7'h7E;

  // Signal loss: empty pulse positions before declaring
  localparam logic [4:0] LOS_EMPTY_SLOTS = 5'h1F;
  // Frame loss: errored framing bits out of the last five
  localparam int unsigned FB_WINDOW   = 5;
  localparam logic [2:0]  FB_ERR_LIMIT = 3'h2;

  // Limits and defaults of the configuration
  localparam logic [3:0]  ENTRY_MIN   = 4'h5;
  localparam logic [3:0]  ENTRY_MAX   = 4'hF;
  localparam logic [3:0]  ENTRY_DEF   = 4'hA;
  localparam logic [9:0]  SEVERE_MIN  = 10'h001;
  localparam logic [9:0]  SEVERE_MAX  = 10'h3E8;
  localparam logic [9:0]  SEVERE_DEF  = 10'h140;
  localparam logic [2:0]  ERWIN_MIN   = 3'h1;
  localparam logic [2:0]  ERWIN_MAX   = 3'h5;
  localparam logic [2:0]  ERWIN_DEF   = 3'h2;
  localparam logic [12:0] FILT_MIN_MS = 13'h0032;
  localparam logic [12:0] FILT_MAX_MS = 13'h1388;
  localparam logic [12:0] FILT_DEF_MS = 13'h007D;
  localparam logic [4:0]  HOURS_MIN   = 5'h01;
  localparam logic [4:0]  HOURS_MAX   = 5'h18;
  localparam logic [4:0]  HOURS_DEF   = 5'h01;

  // Direction index
  localparam int unsigned DIR_DN = 0;
  localparam int unsigned DIR_UP = 1;

  typedef enum logic {
    TLQM_AVAIL   = 1'b0,
    TLQM_UNAVAIL = 1'b1
  } tlqm_avail_t;

  typedef struct packed {
    logic [3:0]  unavail_entry_count;
    logic [3:0]  avail_entry_count;
    logic [9:0]  severe_crc_threshold;
    logic [2:0]  error_rate_window;
    logic [12:0] alarm_filter_time;
    logic [12:0] remote_alarm_filter_time;
    logic        base_interval_long;
    logic [4:0]  disturb_interval_hours;
  } tlqm_cfg_t;

  localparam tlqm_cfg_t CFG_DEFAULT = '{
    unavail_entry_count:      ENTRY_DEF,
    avail_entry_count:        ENTRY_DEF,
    severe_crc_threshold:     SEVERE_DEF,
    error_rate_window:        ERWIN_DEF,
    alarm_filter_time:        FILT_DEF_MS,
    remote_alarm_filter_time: FILT_DEF_MS,
    base_interval_long:       1'b0,
    disturb_interval_hours:   HOURS_DEF
  };

  typedef struct packed {
    logic [7:0] errored_second_dn;
    logic [7:0] errored_second_up;
    logic [7:0] severely_errored_second_dn;
    logic [7:0] severely_errored_second_up;
    logic [7:0] unavailable_seconds_dn;
    logic [7:0] unavailable_seconds_up;
    logic [7:0] slip_count;
  } tlqm_rep_t;

  typedef struct packed {
    logic [15:0] disturb_dn;
    logic [15:0] disturb_up;
    logic [15:0] slip_count;
  } tlqm_drep_t;

endpackage : tlqm_pkg

// file: design/tlqm_alarm_filter.sv
// Persistence filter for one alarm, in millisecond steps
`timescale 1ns/1ps
`default_nettype none
module tlqm_alarm_filter (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Time base and setting
  input  wire logic        ms_tick,
  input  wire logic [12:0] filt_ms,
  // Alarm
  input  wire logic        raw,
  output logic             filt_ff
);

  logic [12:0] hold_ff;

  // Any bounce back to the filtered level restarts the wait
  always_ff @(posedge mclk) begin
    if (rst) begin
      hold_ff <= 13'h0000;
      filt_ff <= 1'b0;
    end else if (raw == filt_ff) begin
      hold_ff <= 13'h0000;
    end else if (ms_tick) begin
      if (hold_ff + 13'h0001 >= filt_ms) begin
        filt_ff <= raw;
        hold_ff <= 13'h0000;
      end else begin
        hold_ff <= hold_ff + 13'h0001;
      end
    end
  end

endmodule : tlqm_alarm_filter
`default_nettype wire

// file: design/tlqm_monitor.sv
// Line quality monitor: alarms, per-second accounting and reports
//
// Summary of operation
// - Downstream severe second: CRC threshold or alarm
// - Upstream severe second on any remote alarm
// - Unavailable direction halts all errored counting
// - Report errored counters every base interval
// - Availability tracked per direction independently
// - Enter unavailable after run; run counts unavailable
// - Leave after clean run; run counts available
// - Count and report unavailable seconds per direction
// - Configuration writes refused while path enabled
// - Entry counts 5 to 15, default 10
// - Severe CRC threshold 1 to 1000, default 320
// - Error rate window 1 to 5, default 2
// - Alarm filter 50 to 5000 ms, default 125
// - Separate remote alarm filter, same range
// - Base interval is 60 or 126 seconds
// - Disturbance interval 1 to 24 hours
// - Multidrop sends all-ones on port B
// - Multidrop output follows filtered alarms only
// - Multidrop starts after reset or on cascade change
// - Signal loss after 31 empty pulse positions
// - Frame loss on 2 of 5 or signal loss
`timescale 1ns/1ps
`default_nettype none
module tlqm_monitor #(
  parameter int unsigned MS_CYC            = tlqm_pkg::MS_CYCLES,
  parameter int unsigned EXCESS_ERROR_RATE_CRC_PER_SEC = 16
) (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst,
  // Line port A receive events
  input  wire logic                pulse_slot,
  input  wire logic                pulse_seen,
  input  wire logic                framing_bit_valid,
  input  wire logic                framing_bit_err,
  input  wire logic                frame_align_ok,
  input  wire logic                all_ones_det,
  input  wire logic                remote_alarm_det,
  input  wire logic                crc_err,
  input  wire logic                slip,
  // Supervisor control
  input  wire logic                dp_enable,
  input  wire logic                cfg_wr,
  input  wire tlqm_pkg::tlqm_cfg_t cfg_in,
  input  wire logic                net_topology_cascade,
  output tlqm_pkg::tlqm_cfg_t      cfg_ff,
  output logic                     cfg_reject_ff,
  // Alarm status
  output logic                     signal_loss_ff,
  output logic                     frame_alignment_loss_ff,
  output logic                     excess_error_rate_ff,
  output logic [1:0]               unavail_ff,
  // Reports
  output logic                     report_valid_ff,
  output tlqm_pkg::tlqm_rep_t      report_ff,
  output logic                     drep_valid_ff,
  output tlqm_pkg::tlqm_drep_t     drep_ff,
  // Line port B transmit
  output logic                     multidrop_active_ff,
  output logic                     port_b_ais_ff
);

  // Time base
  logic [31:0] ms_div_ff;
  logic [9:0]  ms_in_sec_ff;
  logic        ms_tick_ff;
  logic        sec_tick_ff;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ms_div_ff    <= 32'h00000000;
      ms_in_sec_ff <= 10'h000;
      ms_tick_ff   <= 1'b0;
      sec_tick_ff  <= 1'b0;
    end else begin
      ms_tick_ff  <= 1'b0;
      sec_tick_ff <= 1'b0;
      if (ms_div_ff == 32'(MS_CYC - 1)) begin
        ms_div_ff  <= 32'h00000000;
        ms_tick_ff <= 1'b1;
        if (ms_in_sec_ff == 10'(tlqm_pkg::MS_PER_SEC - 1)) begin
          ms_in_sec_ff <= 10'h000;
          sec_tick_ff  <= 1'b1;
        end else begin
          ms_in_sec_ff <= ms_in_sec_ff + 10'h001;
        end
      end else begin
        ms_div_ff <= ms_div_ff + 32'h00000001;
      end
    end
  end

  // Configuration, held while the path is enabled
  function automatic logic cfg_ok(input tlqm_pkg::tlqm_cfg_t c);
    cfg_ok = c.unavail_entry_count >= tlqm_pkg::ENTRY_MIN
          && c.avail_entry_count >= tlqm_pkg::ENTRY_MIN
          && c.severe_crc_threshold >= tlqm_pkg::SEVERE_MIN
          && c.severe_crc_threshold <= tlqm_pkg::SEVERE_MAX
          && c.error_rate_window >= tlqm_pkg::ERWIN_MIN
          && c.error_rate_window <= tlqm_pkg::ERWIN_MAX
          && c.alarm_filter_time >= tlqm_pkg::FILT_MIN_MS
          && c.alarm_filter_time <= tlqm_pkg::FILT_MAX_MS
          && c.remote_alarm_filter_time >= tlqm_pkg::FILT_MIN_MS
          && c.remote_alarm_filter_time <= tlqm_pkg::FILT_MAX_MS
          && c.disturb_interval_hours >= tlqm_pkg::HOURS_MIN
          && c.disturb_interval_hours <= tlqm_pkg::HOURS_MAX;
  endfunction : cfg_ok

  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_ff        <= tlqm_pkg::CFG_DEFAULT;
      cfg_reject_ff <= 1'b0;
    end else begin
      cfg_reject_ff <= 1'b0;
      if (cfg_wr) begin
        if (dp_enable || !cfg_ok(cfg_in)) begin
          cfg_reject_ff <= 1'b1;
        end else begin
          cfg_ff <= cfg_in;
        end
      end
    end
  end

  // Enabling the path restarts error, availability and interval counting from zero; alarm detectors keep running
  logic dp_enable_d_ff;
  logic restart;

  always_ff @(posedge mclk) begin
    if (rst) begin
      dp_enable_d_ff <= 1'b0;
    end else begin
      dp_enable_d_ff <= dp_enable;
    end
  end
  assign restart = dp_enable && !dp_enable_d_ff;

  // Signal loss detection
  logic [4:0] empty_run_ff;
  logic       los_set;

  assign los_set = pulse_slot && !pulse_seen
                && empty_run_ff == tlqm_pkg::LOS_EMPTY_SLOTS - 5'h01;

  always_ff @(posedge mclk) begin
    if (rst) begin
      empty_run_ff   <= 5'h00;
      signal_loss_ff <= 1'b0;
    end else begin
      if (pulse_slot) begin
        if (pulse_seen) begin
          empty_run_ff <= 5'h00;
        end else if (empty_run_ff != tlqm_pkg::LOS_EMPTY_SLOTS) begin
          empty_run_ff <= empty_run_ff + 5'h01;
        end
      end
      if (los_set) begin
        signal_loss_ff <= 1'b1;
      end else if (frame_align_ok) begin
        signal_loss_ff <= 1'b0;
      end
    end
  end

  // Frame loss detection over the last five framing bits
  logic [tlqm_pkg::FB_WINDOW-1:0] fb_hist_ff;
  logic [tlqm_pkg::FB_WINDOW-1:0] fb_next;
  logic [2:0]                     fb_errs;
  logic                           lof_set;

  always_comb begin
    fb_next = {fb_hist_ff[tlqm_pkg::FB_WINDOW-2:0], framing_bit_err};
    fb_errs = 3'h0;
    for (int i = 0; i < tlqm_pkg::FB_WINDOW; i++) begin
      fb_errs = fb_errs + {2'h0, fb_next[i]};
    end
  end
  assign lof_set = (framing_bit_valid && fb_errs >= tlqm_pkg::FB_ERR_LIMIT) || los_set;

  always_ff @(posedge mclk) begin
    if (rst) begin
      fb_hist_ff              <= '0;
      frame_alignment_loss_ff <= 1'b0;
    end else begin
      if (framing_bit_valid) begin
        fb_hist_ff <= fb_next;
      end else if (frame_align_ok) begin
        fb_hist_ff <= '0;
      end
      if (lof_set) begin
        frame_alignment_loss_ff <= 1'b1;
      end else if (frame_align_ok) begin
        frame_alignment_loss_ff <= 1'b0;
      end
    end
  end

  // Raw alarm levels and their filtered versions
  logic ais_raw;
  logic los_filt;
  logic lof_filt;
  logic ais_filt;
  logic rai_filt;

  assign ais_raw = frame_alignment_loss_ff && all_ones_det;

  tlqm_alarm_filter u_filt_los (
    .mclk    (mclk),
    .rst     (rst),
    .ms_tick (ms_tick_ff),
    .filt_ms (cfg_ff.alarm_filter_time),
    .raw     (signal_loss_ff),
    .filt_ff (los_filt)
  );
  tlqm_alarm_filter u_filt_lof (
    .mclk    (mclk),
    .rst     (rst),
    .ms_tick (ms_tick_ff),
    .filt_ms (cfg_ff.alarm_filter_time),
    .raw     (frame_alignment_loss_ff),
    .filt_ff (lof_filt)
  );
  tlqm_alarm_filter u_filt_ais (
    .mclk    (mclk),
    .rst     (rst),
    .ms_tick (ms_tick_ff),
    .filt_ms (cfg_ff.alarm_filter_time),
    .raw     (ais_raw),
    .filt_ff (ais_filt)
  );
  tlqm_alarm_filter u_filt_rai (
    .mclk    (mclk),
    .rst     (rst),
    .ms_tick (ms_tick_ff),
    .filt_ms (cfg_ff.remote_alarm_filter_time),
    .raw     (remote_alarm_det),
    .filt_ff (rai_filt)
  );

  // Per-second event collection; events in the tick cycle still count
  logic [9:0] crc_sec_ff;
  logic       dn_alarm_sec_ff;
  logic       up_alarm_sec_ff;
  logic       slip_sec_ff;
  logic [9:0] crc_now;
  logic       dn_alarm_now;
  logic       up_alarm_now;
  logic       slip_now;

  assign crc_now      = (crc_err && crc_sec_ff != 10'h3FF) ? crc_sec_ff + 10'h001 : crc_sec_ff;
  assign dn_alarm_now = dn_alarm_sec_ff || signal_loss_ff || frame_alignment_loss_ff || ais_raw;
  assign up_alarm_now = up_alarm_sec_ff || remote_alarm_det;
  assign slip_now     = slip_sec_ff || slip;

  always_ff @(posedge mclk) begin
    if (rst || sec_tick_ff || restart) begin
      crc_sec_ff      <= 10'h000;
      dn_alarm_sec_ff <= 1'b0;
      up_alarm_sec_ff <= 1'b0;
      slip_sec_ff     <= 1'b0;
    end else begin
      crc_sec_ff      <= crc_now;
      dn_alarm_sec_ff <= dn_alarm_now;
      up_alarm_sec_ff <= up_alarm_now;
      slip_sec_ff     <= slip_now;
    end
  end

  logic [1:0] ses_now;
  logic [1:0] es_now;

  assign ses_now[tlqm_pkg::DIR_DN] = crc_now >= cfg_ff.severe_crc_threshold
                                  || dn_alarm_now;
  assign ses_now[tlqm_pkg::DIR_UP] = up_alarm_now;
  assign es_now[tlqm_pkg::DIR_DN]  = crc_now != 10'h000 || dn_alarm_now || slip_now;
  assign es_now[tlqm_pkg::DIR_UP]  = up_alarm_now;

  // Excess error rate over a window of whole seconds
  logic [12:0] excess_error_rate_sum_ff;
  logic [2:0]  excess_error_rate_secs_ff;
  logic [12:0] excess_error_rate_total;

  assign excess_error_rate_total = excess_error_rate_sum_ff + {3'h0, crc_now};

  always_ff @(posedge mclk) begin
    if (rst || restart) begin
      excess_error_rate_sum_ff         <= 13'h0000;
      excess_error_rate_secs_ff        <= 3'h0;
      excess_error_rate_ff <= 1'b0;
    end else if (sec_tick_ff) begin
      if (excess_error_rate_secs_ff + 3'h1 >= cfg_ff.error_rate_window) begin
        excess_error_rate_ff <= excess_error_rate_total
                             >= 13'(EXCESS_ERROR_RATE_CRC_PER_SEC * cfg_ff.error_rate_window);
        excess_error_rate_sum_ff         <= 13'h0000;
        excess_error_rate_secs_ff        <= 3'h0;
      end else begin
        excess_error_rate_sum_ff  <= excess_error_rate_total;
        excess_error_rate_secs_ff <= excess_error_rate_secs_ff + 3'h1;
      end
    end
  end

  // Availability per direction
  tlqm_pkg::tlqm_avail_t avail_st_ff [2];
  logic [3:0]            run_ff      [2];
  logic [7:0]            uas_ff      [2];
  logic                  report_due;

  always_ff @(posedge mclk) begin
    for (int d = 0; d < 2; d++) begin
      if (rst || restart) begin
        avail_st_ff[d] <= tlqm_pkg::TLQM_AVAIL;
        run_ff[d]      <= 4'h0;
        uas_ff[d]      <= 8'h00;
      end else if (sec_tick_ff) begin
        if (report_due) begin
          uas_ff[d] <= 8'h00;
        end
        case (avail_st_ff[d])
          tlqm_pkg::TLQM_AVAIL: begin
            if (!ses_now[d]) begin
              run_ff[d] <= 4'h0;
            end else if (run_ff[d] + 4'h1 >= cfg_ff.unavail_entry_count) begin
              avail_st_ff[d] <= tlqm_pkg::TLQM_UNAVAIL;
              run_ff[d]      <= 4'h0;
              uas_ff[d]      <= (report_due ? 8'h00 : uas_ff[d])
                              + {4'h0, cfg_ff.unavail_entry_count};
            end else begin
              run_ff[d] <= run_ff[d] + 4'h1;
            end
          end
          tlqm_pkg::TLQM_UNAVAIL: begin
            if (ses_now[d]) begin
              run_ff[d] <= 4'h0;
              uas_ff[d] <= (report_due ? 8'h00 : uas_ff[d]) + 8'h01;
            end else if (run_ff[d] + 4'h1 >= cfg_ff.avail_entry_count) begin
              avail_st_ff[d] <= tlqm_pkg::TLQM_AVAIL;
              run_ff[d]      <= 4'h0;
              uas_ff[d]      <= (report_due || uas_ff[d] < {4'h0, run_ff[d]})
                              ? 8'h00 : uas_ff[d] - {4'h0, run_ff[d]};
            end else begin
              run_ff[d] <= run_ff[d] + 4'h1;
              uas_ff[d] <= (report_due ? 8'h00 : uas_ff[d]) + 8'h01;
            end
          end
          default: begin
            avail_st_ff[d] <= tlqm_pkg::TLQM_AVAIL;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      unavail_ff <= 2'h0;
    end else begin
      unavail_ff <= {avail_st_ff[1] == tlqm_pkg::TLQM_UNAVAIL,
                     avail_st_ff[0] == tlqm_pkg::TLQM_UNAVAIL};
    end
  end

  // Base interval counting and report
  logic [6:0] bi_sec_ff;
  logic       any_unavail;
  logic [7:0] es_ff  [2];
  logic [7:0] ses_ff [2];
  logic [7:0] slip_ff;

  assign report_due  = bi_sec_ff + 7'h01 >= (cfg_ff.base_interval_long
                     ? tlqm_pkg::BI_LONG_S : tlqm_pkg::BI_SHORT_S);
  assign any_unavail = avail_st_ff[0] == tlqm_pkg::TLQM_UNAVAIL
                    || avail_st_ff[1] == tlqm_pkg::TLQM_UNAVAIL;

  always_ff @(posedge mclk) begin
    if (rst || restart) begin
      bi_sec_ff <= 7'h00;
      slip_ff   <= 8'h00;
      for (int d = 0; d < 2; d++) begin
        es_ff[d]  <= 8'h00;
        ses_ff[d] <= 8'h00;
      end
    end else if (sec_tick_ff) begin
      bi_sec_ff <= report_due ? 7'h00 : bi_sec_ff + 7'h01;
      slip_ff   <= report_due ? 8'h00 : slip_ff + {7'h00, slip_now};
      for (int d = 0; d < 2; d++) begin
        if (report_due) begin
          es_ff[d]  <= 8'h00;
          ses_ff[d] <= 8'h00;
        end else if (!any_unavail) begin
          es_ff[d]  <= es_ff[d] + {7'h00, es_now[d]};
          ses_ff[d] <= ses_ff[d] + {7'h00, ses_now[d]};
        end
      end
    end
  end

  // Report shows the interval just closed, this second included except in the unavailable second counts
  always_ff @(posedge mclk) begin
    if (rst) begin
      report_valid_ff <= 1'b0;
      report_ff       <= '0;
    end else begin
      report_valid_ff <= 1'b0;
      if (sec_tick_ff && report_due && dp_enable && !restart) begin
        report_valid_ff                      <= 1'b1;
        report_ff.errored_second_dn          <= es_ff[0] + {7'h00, es_now[0] && !any_unavail};
        report_ff.errored_second_up          <= es_ff[1] + {7'h00, es_now[1] && !any_unavail};
        report_ff.severely_errored_second_dn <= ses_ff[0] + {7'h00, ses_now[0] && !any_unavail};
        report_ff.severely_errored_second_up <= ses_ff[1] + {7'h00, ses_now[1] && !any_unavail};
        report_ff.unavailable_seconds_dn     <= uas_ff[0];
        report_ff.unavailable_seconds_up     <= uas_ff[1];
        report_ff.slip_count                 <= slip_ff + {7'h00, slip_now};
      end
    end
  end

  // Disturbance and slip counting over whole hours
  logic [11:0] hr_sec_ff;
  logic [4:0]  hours_ff;
  logic        dn_alarm_d_ff;
  logic        up_alarm_d_ff;
  logic        dn_alarm_lvl;
  logic        hour_end;
  logic        drep_due;

  assign dn_alarm_lvl = signal_loss_ff || frame_alignment_loss_ff || ais_raw;
  assign hour_end     = sec_tick_ff && hr_sec_ff == 12'(tlqm_pkg::SEC_PER_HOUR - 1);
  assign drep_due     = hour_end && hours_ff + 5'h01 >= cfg_ff.disturb_interval_hours;

  always_ff @(posedge mclk) begin
    if (rst || restart) begin
      hr_sec_ff     <= 12'h000;
      hours_ff      <= 5'h00;
      dn_alarm_d_ff <= 1'b0;
      up_alarm_d_ff <= 1'b0;
      drep_valid_ff <= 1'b0;
      drep_ff       <= '0;
    end else begin
      dn_alarm_d_ff <= dn_alarm_lvl;
      up_alarm_d_ff <= remote_alarm_det;
      drep_valid_ff <= drep_due && dp_enable;
      if (sec_tick_ff) begin
        hr_sec_ff <= hour_end ? 12'h000 : hr_sec_ff + 12'h001;
      end
      if (hour_end) begin
        hours_ff <= drep_due ? 5'h00 : hours_ff + 5'h01;
      end
      // Counts restart on the report strobe; events in the due cycle and the strobe cycle are dropped
      if (drep_valid_ff) begin
        drep_ff <= '0;
      end else if (!drep_due) begin
        drep_ff.disturb_dn <= drep_ff.disturb_dn + {15'h0000, dn_alarm_lvl && !dn_alarm_d_ff};
        drep_ff.disturb_up <= drep_ff.disturb_up
                            + {15'h0000, remote_alarm_det && !up_alarm_d_ff};
        drep_ff.slip_count <= drep_ff.slip_count + {15'h0000, slip};
      end
    end
  end

  // Multidrop start and all-ones forwarding to port B
  logic topo_d_ff;
  logic booted_ff;

  always_ff @(posedge mclk) begin
    if (rst) begin
      booted_ff           <= 1'b0;
      topo_d_ff           <= 1'b0;
      multidrop_active_ff <= 1'b0;
    end else begin
      booted_ff <= 1'b1;
      topo_d_ff <= net_topology_cascade;
      if (!booted_ff) begin
        multidrop_active_ff <= net_topology_cascade;
      end else if (net_topology_cascade && !topo_d_ff) begin
        multidrop_active_ff <= 1'b1;
      end else if (!net_topology_cascade && topo_d_ff) begin
        multidrop_active_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      port_b_ais_ff <= 1'b0;
    end else begin
      port_b_ais_ff <= multidrop_active_ff && (los_filt || lof_filt || ais_filt);
    end
  end

  // Remote alarm after filtering drives no output; upstream counting uses the raw remote alarm
  logic rai_status_unused;
  assign rai_status_unused = rai_filt;

endmodule : tlqm_monitor
`default_nettype wire

// file: sim/tlqm_monitor_checker.sv
// Port assertions of the line quality monitor
`timescale 1ns/1ps
`default_nettype none
module tlqm_monitor_checker (
  // Clock, reset and controls
  input wire logic                mclk, rst, cfg_wr, dp_enable, pulse_slot, frame_align_ok,
  input wire tlqm_pkg::tlqm_cfg_t cfg_in, cfg_ff,
  // Observed outputs
  input wire logic                cfg_reject_ff, signal_loss_ff, frame_alignment_loss_ff,
  input wire logic                report_valid_ff, multidrop_active_ff, port_b_ais_ff
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_lock_refuse: assert property (cfg_wr && dp_enable |=> cfg_reject_ff && $stable(cfg_ff))
    else $error("locked write taken");
  a_cfg_take: assert property (cfg_wr && !dp_enable |=> cfg_reject_ff || cfg_ff == $past(cfg_in))
    else $error("write neither taken nor refused");
  a_entry_range: assert property (cfg_wr && cfg_in.unavail_entry_count < 4'h5 |=> cfg_reject_ff)
    else $error("short entry count taken");
  a_thr_range: assert property (cfg_wr && cfg_in.severe_crc_threshold > 10'h3E8 |=> cfg_reject_ff)
    else $error("large threshold taken");
  a_los_slot: assert property ($rose(signal_loss_ff) |-> $past(pulse_slot))
    else $error("signal loss without slot");
  a_lof_los: assert property ($rose(signal_loss_ff) |-> ##[0:1] frame_alignment_loss_ff)
    else $error("no frame loss on signal loss");
  a_los_clear: assert property (frame_align_ok && !pulse_slot |=> !signal_loss_ff)
    else $error("signal loss kept");
  a_ais_mdrop: assert property (port_b_ais_ff |-> $past(multidrop_active_ff))
    else $error("all ones sent outside multidrop");
  a_rep_pulse: assert property (report_valid_ff |=> !report_valid_ff)
    else $error("report strobe too long");
endmodule : tlqm_monitor_checker
`default_nettype wire

// file: sim/tlqm_line_model.sv
// Line side model: pulse positions and framing bits
`timescale 1ns/1ps
`default_nettype none
module tlqm_line_model (
  // Clock and line faults
  input  wire logic mclk, quiet, ferr,
  // Receive strobes
  output logic      pulse_slot, pulse_seen, framing_bit_valid, framing_bit_err
);
  logic [2:0] ph_ff = 3'h0;
  always @(negedge mclk) ph_ff <= ph_ff + 3'h1;
  assign pulse_slot = ph_ff[1:0] == 2'h0;
  // Qualifiers toggle off strobe so stale values never look valid
  assign pulse_seen = pulse_slot ? !quiet : ph_ff[0];
  assign framing_bit_valid = ph_ff == 3'h4;
  assign framing_bit_err = framing_bit_valid ? ferr : ph_ff[1];
endmodule : tlqm_line_model
`default_nettype wire

// file: sim/tlqm_monitor_bench.sv
// Self-checking bench of the line quality monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,s) begin checked++; if ((s)!==(e)) begin fails++; $display("BAD %s exp %0h got %0h",n,e,s); end end
module tlqm_monitor_bench;
  logic mclk = 0, rst = 1, quiet = 0, ferr = 0, fok = 0, aod = 0, rad = 0, crc = 0;
  logic dpe = 0, wr = 0, casc = 0, sl = 0, ps, pv, fv, fe, rej, signal_loss, frame_alignment_loss, all_ones_alarm, rv, md, er;
  logic [1:0] ua;
  logic [3:0] sg;
  tlqm_pkg::tlqm_cfg_t ci = tlqm_pkg::CFG_DEFAULT, cf, c, g;
  tlqm_pkg::tlqm_rep_t rp;
  int fails = 0, checked = 0;
  assign sg = {rv, all_ones_alarm, frame_alignment_loss, signal_loss};
  initial forever #2.5 mclk = ~mclk;
  tlqm_line_model line (.mclk(mclk), .quiet(quiet), .ferr(ferr), .pulse_slot(ps),
    .pulse_seen(pv), .framing_bit_valid(fv), .framing_bit_err(fe));
  tlqm_monitor #(.MS_CYC(1)) dut (.mclk(mclk), .rst(rst), .pulse_slot(ps), .pulse_seen(pv),
    .framing_bit_valid(fv), .framing_bit_err(fe), .frame_align_ok(fok), .all_ones_det(aod),
    .remote_alarm_det(rad), .crc_err(crc), .slip(sl), .dp_enable(dpe), .cfg_wr(wr),
    .cfg_in(ci), .net_topology_cascade(casc), .cfg_ff(cf), .cfg_reject_ff(rej),
    .signal_loss_ff(signal_loss), .frame_alignment_loss_ff(frame_alignment_loss), .excess_error_rate_ff(er),
    .unavail_ff(ua), .report_valid_ff(rv), .report_ff(rp), .drep_valid_ff(), .drep_ff(),
    .multidrop_active_ff(md), .port_b_ais_ff(all_ones_alarm));
  task cyc(input int n); repeat (n) @(negedge mclk); endtask : cyc
  task end_sim;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // Bounded wait on one status bit, a miss ends the run
  task wv(input int k, input logic v, input int n);
    for (int i = 0; i < n && sg[k] !== v; i++) cyc(1);
    `CHK("wait", v, sg[k])
    if (sg[k] !== v) end_sim;
  endtask : wv
  task wcf(input tlqm_pkg::tlqm_cfg_t v, input logic en, input logic r);
    ci = v; dpe = en; wr = 1; cyc(1);
    `CHK("reject", r, rej)
    wr = 0; cyc(1);
    if (!r) `CHK("cfg", v, cf)
  endtask : wcf
  task t_cfg;
    `CHK("default", tlqm_pkg::CFG_DEFAULT, cf)
    g = '{4'h5, 4'h5, 10'h001, 3'h1, 13'h0032, 13'h0032, 1'b0, 5'h01};
    for (int i = 0; i < 7; i++) begin
      c = g;
      case (i)
        0: c.unavail_entry_count = 4'h4;
        1: c.avail_entry_count = 4'h4;
        2: c.severe_crc_threshold = 10'h3E9;
        3: c.error_rate_window = 3'h6;
        4: c.alarm_filter_time = 13'h0031;
        5: c.remote_alarm_filter_time = 13'h1389;
        default: c.disturb_interval_hours = 5'h19;
      endcase
      wcf(c, 0, 1);
    end
    wcf(g, 0, 0);
    wcf(tlqm_pkg::CFG_DEFAULT, 1, 1);
    `CHK("locked", g, cf)
    dpe = 0; $display("test cfg end");
  endtask : t_cfg
  task t_los;
    quiet = 1; cyc(100);
    `CHK("early", 1'b0, signal_loss)
    wv(0, 1, 40); cyc(2);
    `CHK("lof", 1'b1, frame_alignment_loss)
    quiet = 0; fok = 1; cyc(1); fok = 0; cyc(1);
    `CHK("clear", 2'h0, {signal_loss, frame_alignment_loss})
    ferr = 1; wv(1, 1, 40); ferr = 0;
    `CHK("no los", 1'b0, signal_loss)
    fok = 1; cyc(1); fok = 0; $display("test los end");
  endtask : t_los
  task t_md;
    casc = 1; cyc(3);
    `CHK("mdrop", 1'b1, md)
    // All-ones only counts under frame loss, so raise frame loss first
    ferr = 1; wv(1, 1, 40); ferr = 0; aod = 1; cyc(40);
    `CHK("filter on", 1'b0, all_ones_alarm)
    wv(2, 1, 40); aod = 0; fok = 1; cyc(1); fok = 0; cyc(39);
    `CHK("filter off", 1'b1, all_ones_alarm)
    wv(2, 0, 40); casc = 0; $display("test mdrop end");
  endtask : t_md
  task t_rep;
    dpe = 1; cyc(50);
    repeat (3) begin crc = 1; sl = 1; cyc(1); crc = 0; sl = 0; cyc(1999); end
    repeat (2) begin rad = 1; cyc(1); rad = 0; cyc(1999); end
    wv(3, 1, 62000);
    `CHK("ses dn", 8'h03, rp.severely_errored_second_dn)
    `CHK("ses up", 8'h02, rp.severely_errored_second_up)
    `CHK("es dn", 8'h03, rp.errored_second_dn)
    `CHK("uas", 16'h0, {rp.unavailable_seconds_dn, rp.unavailable_seconds_up})
    `CHK("slip", 8'h03, rp.slip_count)
    `CHK("excess_error_rate", 1'b0, er)
    quiet = 1; cyc(8000);
    `CHK("unavail", 2'h1, ua)
    quiet = 0; fok = 1; cyc(1); fok = 0; cyc(6999);
    `CHK("avail", 2'h0, ua)
    $display("test report end");
  endtask : t_rep
  initial begin
    cyc(16); rst = 0; cyc(1);
    t_cfg; t_los; t_md; t_rep;
    end_sim;
  end
endmodule : tlqm_monitor_bench
bind tlqm_monitor tlqm_monitor_checker chk (.mclk(mclk), .rst(rst), .cfg_wr(cfg_wr),
  .dp_enable(dp_enable), .pulse_slot(pulse_slot), .frame_align_ok(frame_align_ok),
  .cfg_in(cfg_in), .cfg_ff(cfg_ff), .cfg_reject_ff(cfg_reject_ff),
  .signal_loss_ff(signal_loss_ff), .frame_alignment_loss_ff(frame_alignment_loss_ff),
  .report_valid_ff(report_valid_ff), .multidrop_active_ff(multidrop_active_ff),
  .port_b_ais_ff(port_b_ais_ff));
`default_nettype wire
